// *** hw/fault_monitor_pkg.sv ***
// Constants and types shared by the auxiliary memory fault monitor.
// What this block does
// [R01] Tape parity error clears requesting control bits.
// [R02] Abort leaves transfer-in-progress bit set.
// [R03] Go and progress bits encode request state.
// [R04] Inhibit switch suppresses group and word aborts.
// [R05] Own supply failure sets alarm bit 4.
// [R06] Tape voltage failure shown in control bit 4.
// [R07] Tape voltage failure mid-transfer aborts, alarm 8.
// [R08] Third reverse without identifier: alarm 11, abort.
// [R09] Bank word count not 1024 sets alarm 7.
// [R10] End-of-bank alarm stops further transfers.
// [R11] Echo lines compared with driven word, strobed.
// [R12] Echo noise failure requests host restart.
// [R13] Zero-forced transmit line requests host restart.
// [R14] Stuck-one line amputates, sets alarms 15, 1.
// [R15] Erasable-cycle parity error: restart, alarm 13.
// [R16] Fixed-cycle parity error: restart, alarm 14.
// [R17] Tape-write core parity error: alarm 12, abort.
// [R18] Triplex correction sets alarm 6 only.
// [R19] Alarm bits stay set until cleared or reset.
package fault_monitor_pkg;

  localparam int WORD_W  = 16;
  localparam int ADDR_W  = 3;

  // Register addresses on the plain port.
  localparam logic [2:0] ADDR_ALARM   = 3'h0;
  localparam logic [2:0] ADDR_MASK    = 3'h1;
  localparam logic [2:0] ADDR_CONTROL = 3'h2;
  localparam logic [2:0] ADDR_STATUS  = 3'h3;

  // Alarm status channel bit positions.
  localparam int ALM_AMPUTATE  = 1;
  localparam int ALM_SUPPLY    = 4;
  localparam int ALM_TRIPLEX_C = 6;
  localparam int ALM_BANK      = 7;
  localparam int ALM_TAPE_VOLT = 8;
  localparam int ALM_TRIPLEX_P = 9;
  localparam int ALM_SIMPLEX_P = 10;
  localparam int ALM_ID_FAIL   = 11;
  localparam int ALM_WORD_PAR  = 12;
  localparam int ALM_ERASABLE  = 13;
  localparam int ALM_FIXED     = 14;
  localparam int ALM_STUCK     = 15;

  // Tape control channel bit positions.
  localparam int CTL_GO        = 0;
  localparam int CTL_PROGRESS  = 1;
  localparam int CTL_READ      = 2;
  localparam int CTL_WRITE     = 3;
  localparam int CTL_VOLT      = 4;
  localparam int CTL_SEARCH    = 5;

  // Control bits that request a tape operation.
  localparam logic [15:0] CTL_REQ_MASK = 16'h002D;

  localparam logic [15:0] ALARM_RST   = 16'h0000;
  localparam logic [15:0] MASK_RST    = 16'h0000;
  localparam logic [15:0] CONTROL_RST = 16'h0000;

  localparam int BANK_WORDS    = 1024;
  localparam int REVERSE_LIMIT = 3;
  localparam int BANK_CNT_W    = 11;

  // Echo strobe delay after driving data.
  localparam int ECHO_DELAY_NS  = 30;
  localparam int CLK_PERIOD_NS  = 10;
  localparam int ECHO_DELAY_CYC = (ECHO_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    EC_IDLE   = 3'b001,
    EC_WAIT   = 3'b010,
    EC_STROBE = 3'b100
  } echo_state_t;

endpackage : fault_monitor_pkg

// *** hw/echo_checker.sv ***
// Echo comparison of host echo lines against the driven buffer word.
`timescale 1ns/100ps
module echo_checker #(
  parameter int W     = 16,
  parameter int DELAY = 3
) (
  // Clock and reset.
  input  wire logic         clock,
  input  wire logic         rst,
  // Transmission.
  input  wire logic         send,
  input  wire logic [W-1:0] word,
  input  wire logic [W-1:0] echo,
  // Stuck-one window: start clears, test checks.
  input  wire logic         win_start,
  input  wire logic         win_test,
  // Results, one-cycle pulses.
  output logic              mismatch,
  output logic              stuck_one
);

  typedef struct packed {
    fault_monitor_pkg::echo_state_t st;
    logic [7:0]                     cnt;
    logic [W-1:0]                   word;
    logic [W-1:0]                   zero_seen;
    logic                           mismatch;
    logic                           stuck_one;
  } st_t;

  st_t s_r;
  st_t s_nxt;

  always_comb begin
    s_nxt           = s_r;
    s_nxt.mismatch  = 1'b0;
    s_nxt.stuck_one = 1'b0;
    case (s_r.st)
      fault_monitor_pkg::EC_IDLE: begin
        if (send) begin
          s_nxt.word = word;
          s_nxt.cnt  = 8'h00;
          s_nxt.st   = fault_monitor_pkg::EC_WAIT;
        end
      end
      fault_monitor_pkg::EC_WAIT: begin
        s_nxt.cnt = s_r.cnt + 8'h01;
        if (s_r.cnt >= 8'(DELAY - 1)) begin
          s_nxt.st = fault_monitor_pkg::EC_STROBE;
        end
      end
      fault_monitor_pkg::EC_STROBE: begin
        // [R11] Bitwise echo compare.
        s_nxt.mismatch = (echo != s_r.word);
        s_nxt.st       = fault_monitor_pkg::EC_IDLE;
      end
      default: s_nxt.st = fault_monitor_pkg::EC_IDLE;
    endcase
    // [R14] Stuck-one detection window.
    if (win_start) begin
      s_nxt.zero_seen = '0;
    end else begin
      s_nxt.zero_seen = s_r.zero_seen | ~echo;
    end
    if (win_test && !win_start) begin
      s_nxt.stuck_one = ~&s_r.zero_seen;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_r    <= '0;
      s_r.st <= fault_monitor_pkg::EC_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign mismatch  = s_r.mismatch;
  assign stuck_one = s_r.stuck_one;

endmodule : echo_checker

// *** hw/aux_memory_fault_monitor.sv ***
// Fault detection, tape abort and alarm reporting for the auxiliary memory.
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/100ps
module aux_memory_fault_monitor #(
  parameter int W = 16
) (
  // Clock and reset.
  input  wire logic         clock,
  input  wire logic         rst,
  // Register port.
  input  wire logic [2:0]   addr,
  input  wire logic [W-1:0] wdata,
  input  wire logic         wr,
  input  wire logic         rd,
  output logic [W-1:0]      rdata,
  // Fault inputs from tape and core logic (same clock).
  input  wire logic         tape_read_parity_err,
  input  wire logic         triplex_group_err,
  input  wire logic         triplex_corrected,
  input  wire logic         simplex_group_err,
  input  wire logic         word_parity_err,
  input  wire logic         write_core_parity_err,
  input  wire logic         erasable_parity_err,
  input  wire logic         fixed_parity_err,
  input  wire logic         reverse_tape_command,
  input  wire logic         id_found,
  input  wire logic         bank_word_done,
  input  wire logic         record_end,
  // Pins from outside the clock domain.
  input  wire logic         abort_inhibit_switch,
  input  wire logic         supply_fail,
  input  wire logic         tape_volt_fail,
  input  wire logic [W-1:0] host_echo_lines,
  // Host data transmission.
  input  wire logic         send,
  input  wire logic [W-1:0] memory_buffer_word,
  input  wire logic         win_start,
  input  wire logic         win_test,
  output logic [W-1:0]      host_data_drive_lines,
  // Results.
  output logic              host_restart_request,
  output logic              amputate,
  output logic              transfer_enable,
  output logic              irq
);

  typedef struct packed {
    logic [W-1:0]                         alarm;
    logic [W-1:0]                         mask;
    logic [W-1:0]                         ctl;
    logic [fault_monitor_pkg::BANK_CNT_W-1:0] words;
    logic [1:0]                           revs;
    logic                                 bank_stop;
    logic                                 restart;
    logic                                 amputated;
    logic [W-1:0]                         drive;
    logic [W-1:0]                         rdata;
    logic                                 irq;
    logic [2:0]                           sync1;
    logic [2:0]                           sync2;
    logic [W-1:0]                         echo1;
    logic [W-1:0]                         echo2;
  } st_t;

  st_t  s_r;
  st_t  s_nxt;
  logic mismatch;
  logic stuck_one;

  echo_checker #(
    .W     (W),
    .DELAY (fault_monitor_pkg::ECHO_DELAY_CYC)
  ) u_echo (
    .clock     (clock),
    .rst       (rst),
    .send      (send),
    .word      (memory_buffer_word),
    .echo      (s_r.echo2),
    .win_start (win_start),
    .win_test  (win_test),
    .mismatch  (mismatch),
    .stuck_one (stuck_one)
  );

  function automatic logic [W-1:0] bit_at(input int pos);
    logic [W-1:0] v;
    v      = '0;
    v[pos] = 1'b1;
    return v;
  endfunction : bit_at

  logic         inhibit;
  logic         volt;
  logic         supply;
  logic         in_prog;
  logic         abort;
  logic [W-1:0] set;

  always_comb begin
    s_nxt       = s_r;
    inhibit     = s_r.sync2[0];
    supply      = s_r.sync2[1];
    volt        = s_r.sync2[2];
    in_prog     = s_r.ctl[fault_monitor_pkg::CTL_PROGRESS];
    set         = '0;
    abort       = 1'b0;
    s_nxt.sync1 = {tape_volt_fail, supply_fail, abort_inhibit_switch};
    s_nxt.sync2 = s_r.sync1;
    s_nxt.echo1 = host_echo_lines;
    s_nxt.echo2 = s_r.echo1;

    // [R01] Tape read parity aborts.
    if (tape_read_parity_err) begin
      abort = 1'b1;
    end
    // [R04] Inhibit switch gates group aborts.
    if (triplex_group_err) begin
      set   = set | bit_at(fault_monitor_pkg::ALM_TRIPLEX_P);
      abort = abort | !inhibit;
    end
    if (simplex_group_err) begin
      set   = set | bit_at(fault_monitor_pkg::ALM_SIMPLEX_P);
      abort = abort | !inhibit;
    end
    if (word_parity_err) begin
      set   = set | bit_at(fault_monitor_pkg::ALM_WORD_PAR);
      abort = abort | !inhibit;
    end
    // [R18] Correction is indication only.
    if (triplex_corrected) begin
      set = set | bit_at(fault_monitor_pkg::ALM_TRIPLEX_C);
    end
    // [R17] Write-side core parity aborts.
    if (write_core_parity_err) begin
      set   = set | bit_at(fault_monitor_pkg::ALM_WORD_PAR);
      abort = 1'b1;
    end
    // [R05] Own supply failure.
    if (supply) begin
      set = set | bit_at(fault_monitor_pkg::ALM_SUPPLY);
    end
    // [R07] Voltage abort while in progress.
    if (volt && in_prog) begin
      set   = set | bit_at(fault_monitor_pkg::ALM_TAPE_VOLT);
      abort = 1'b1;
    end
    // [R08] Third reverse command fails search.
    if (!s_r.ctl[fault_monitor_pkg::CTL_GO] || id_found) begin
      s_nxt.revs = 2'h0;
    end else if (reverse_tape_command) begin
      if (s_r.revs == 2'(fault_monitor_pkg::REVERSE_LIMIT - 1)) begin
        set   = set | bit_at(fault_monitor_pkg::ALM_ID_FAIL);
        abort = 1'b1;
      end else begin
        s_nxt.revs = s_r.revs + 2'h1;
      end
    end
    // [R09] Count bank words.
    if (!s_r.ctl[fault_monitor_pkg::CTL_GO]) begin
      s_nxt.words     = '0;
      s_nxt.bank_stop = 1'b0;
    end else if (bank_word_done && !s_r.words[fault_monitor_pkg::BANK_CNT_W-1]) begin
      s_nxt.words = s_r.words + 11'h001;
    end
    if (bank_word_done && s_r.words == 11'(fault_monitor_pkg::BANK_WORDS)) begin
      set             = set | bit_at(fault_monitor_pkg::ALM_BANK);
      s_nxt.bank_stop = 1'b1;
    end
    if (record_end && s_r.words != 11'(fault_monitor_pkg::BANK_WORDS)) begin
      set             = set | bit_at(fault_monitor_pkg::ALM_BANK);
      s_nxt.bank_stop = 1'b1;
    end
    // [R15] Erasable-cycle parity.
    if (erasable_parity_err) begin
      set = set | bit_at(fault_monitor_pkg::ALM_ERASABLE);
    end
    // [R16] Fixed-cycle parity.
    if (fixed_parity_err) begin
      set = set | bit_at(fault_monitor_pkg::ALM_FIXED);
    end
    // [R14] Stuck-one amputation.
    if (stuck_one) begin
      set             = set | bit_at(fault_monitor_pkg::ALM_STUCK)
                            | bit_at(fault_monitor_pkg::ALM_AMPUTATE);
      s_nxt.amputated = 1'b1;
    end
    // [R12] [R13] Echo mismatch restarts host.
    s_nxt.restart = mismatch | stuck_one | erasable_parity_err | fixed_parity_err;

    // Register writes; set wins over write-one-to-clear.
    s_nxt.rdata = '0;
    if (wr && addr == fault_monitor_pkg::ADDR_MASK) begin
      s_nxt.mask = wdata;
    end
    if (wr && addr == fault_monitor_pkg::ADDR_CONTROL) begin
      s_nxt.ctl = wdata & ~bit_at(fault_monitor_pkg::CTL_VOLT);
    end
    // [R19] Sticky alarms.
    if (wr && addr == fault_monitor_pkg::ADDR_ALARM) begin
      s_nxt.alarm = (s_r.alarm & ~wdata) | set;
    end else begin
      s_nxt.alarm = s_r.alarm | set;
    end
    // [R01] [R02] Clear request bits, keep progress.
    if (abort) begin
      s_nxt.ctl = s_nxt.ctl & ~fault_monitor_pkg::CTL_REQ_MASK;
    end
    // [R06] Voltage status bit.
    s_nxt.ctl[fault_monitor_pkg::CTL_VOLT] = volt;
    if (rd) begin
      case (addr)
        fault_monitor_pkg::ADDR_ALARM:   s_nxt.rdata = s_r.alarm;
        fault_monitor_pkg::ADDR_MASK:    s_nxt.rdata = s_r.mask;
        // [R03] Go and progress readable together.
        fault_monitor_pkg::ADDR_CONTROL: s_nxt.rdata = s_r.ctl;
        fault_monitor_pkg::ADDR_STATUS:  s_nxt.rdata = {13'h0000, s_r.bank_stop,
                                                        s_r.amputated, s_r.restart};
        default:                         s_nxt.rdata = '0;
      endcase
    end
    s_nxt.drive = s_r.amputated ? '0 : memory_buffer_word;
    s_nxt.irq   = |(s_nxt.alarm & s_nxt.mask);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_r       <= '0;
      s_r.alarm <= fault_monitor_pkg::ALARM_RST;
      s_r.mask  <= fault_monitor_pkg::MASK_RST;
      s_r.ctl   <= fault_monitor_pkg::CONTROL_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata                 = s_r.rdata;
  assign host_data_drive_lines = s_r.drive;
  assign host_restart_request  = s_r.restart;
  assign amputate              = s_r.amputated;
  // [R10] No transfers after bank alarm.
  assign transfer_enable       = s_r.ctl[fault_monitor_pkg::CTL_GO] & ~s_r.bank_stop;
  assign irq                   = s_r.irq;

endmodule : aux_memory_fault_monitor

// *** testbench/fault_monitor_assertions.sv ***
// Checker of abort, restart and amputation behaviour at the monitor ports.
`timescale 1ns/100ps
module fault_monitor_assertions #(
  parameter int W = 16
) (
  // Clock and reset.
  input wire logic         clock,
  input wire logic         rst,
  // Fault inputs.
  input wire logic         tape_read_parity_err,
  input wire logic         triplex_group_err,
  input wire logic         triplex_corrected,
  input wire logic         simplex_group_err,
  input wire logic         word_parity_err,
  input wire logic         write_core_parity_err,
  input wire logic         erasable_parity_err,
  input wire logic         fixed_parity_err,
  input wire logic         abort_inhibit_switch,
  // Results.
  input wire logic [W-1:0] host_data_drive_lines,
  input wire logic         host_restart_request,
  input wire logic         amputate,
  input wire logic         transfer_enable
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  tape_abort_a: assert property (tape_read_parity_err |-> ##[1:3] !transfer_enable)
    else $error("tape parity did not abort");
  parity_abort_a: assert property (!abort_inhibit_switch [*4] ##0
    (word_parity_err || simplex_group_err || triplex_group_err) |-> ##[1:3] !transfer_enable)
    else $error("parity fault did not abort");
  inhibit_hold_a: assert property (abort_inhibit_switch [*4] ##0
    (transfer_enable && triplex_group_err) |=> transfer_enable)
    else $error("inhibited abort still taken");
  core_abort_a: assert property (write_core_parity_err |-> ##[1:3] !transfer_enable)
    else $error("core parity did not abort");
  core_quiet_a: assert property (write_core_parity_err && !erasable_parity_err
    && !fixed_parity_err |=> !host_restart_request ##1 !host_restart_request)
    else $error("core parity requested restart");
  corrected_hold_a: assert property (triplex_corrected && transfer_enable
    |=> transfer_enable)
    else $error("correction stopped transfer");
  erasable_restart_a: assert property (erasable_parity_err
    |-> ##[1:2] host_restart_request)
    else $error("no restart on erasable parity");
  fixed_restart_a: assert property (fixed_parity_err
    |-> ##[1:2] host_restart_request)
    else $error("no restart on fixed parity");
  amputate_drive_a: assert property (amputate ##1 amputate
    |-> host_data_drive_lines == '0)
    else $error("lines driven after amputation");

  cover property (erasable_parity_err ##[1:2] host_restart_request);
  cover property ($rose(amputate));
  cover property (abort_inhibit_switch && triplex_group_err && transfer_enable);
endmodule : fault_monitor_assertions

bind aux_memory_fault_monitor fault_monitor_assertions #(.W(W)) chk (.*);

// *** testbench/host_echo_model.sv ***
// Host model that echoes the drive lines, with selectable line faults.
`timescale 1ns/100ps
module host_echo_model (
  // Lines from the monitor and fault choice.
  input  wire logic [15:0] drive,
  input  wire logic [1:0]  mode,
  // Echo back to the monitor.
  output logic [15:0]      echo
);
  always_comb begin
    case (mode)
      2'h1:    echo = drive ^ 16'h0008;
      2'h2:    echo = drive & 16'hFFFE;
      2'h3:    echo = drive | 16'h8000;
      default: echo = drive;
    endcase
  end
endmodule : host_echo_model

// *** testbench/tb.sv ***
// Self-checking bench for the auxiliary memory fault monitor.
`timescale 1ns/100ps
module tb;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [2:0]  addr = 3'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [14:0] f = 15'h0000;
  logic [2:0]  lv = 3'h0;
  logic [15:0] mbw = 16'h0000;
  logic [1:0]  mode = 2'h0;
  logic [15:0] rdata, drv, echo;
  logic        rr, amp, ten, irq;
  int          error_cnt = 0;
  int          n_compared = 0;
  int          rr_cnt = 0;
  int          cyc = 0;

  host_echo_model host (.drive(drv), .mode(mode), .echo(echo));
  aux_memory_fault_monitor dut (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .tape_read_parity_err(f[0]),
    .triplex_group_err(f[1]), .triplex_corrected(f[2]), .simplex_group_err(f[3]),
    .word_parity_err(f[4]), .write_core_parity_err(f[5]), .erasable_parity_err(f[6]),
    .fixed_parity_err(f[7]), .reverse_tape_command(f[8]), .id_found(f[9]),
    .bank_word_done(f[10]), .record_end(f[11]), .abort_inhibit_switch(lv[0]),
    .supply_fail(lv[1]), .tape_volt_fail(lv[2]), .host_echo_lines(echo), .send(f[12]),
    .memory_buffer_word(mbw), .win_start(f[13]), .win_test(f[14]),
    .host_data_drive_lines(drv), .host_restart_request(rr), .amputate(amp),
    .transfer_enable(ten), .irq(irq));

  initial begin
    forever #5 clock = ~clock;
  end

  task automatic test_done();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  // Restart pulses are counted; a hang ends the run.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (rr === 1'b1) rr_cnt <= rr_cnt + 1;
    if (cyc == 8000) begin
      error_cnt++;
      test_done();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [2:0] a, input logic [15:0] e);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask : rd_chk

  task automatic hold(input int i, input int n);
    @(posedge clock);
    f[i] <= 1'b1;
    repeat (n) @(posedge clock);
    f[i] <= 1'b0;
  endtask : hold

  task automatic run_case(input int i, input logic inh, input logic [15:0] c,
                          input logic [15:0] ce, input logic [15:0] ae, input int n);
    int r;
    r = rr_cnt;
    lv[0] <= inh;
    wr_reg(fault_monitor_pkg::ADDR_CONTROL, c);
    repeat (4) @(posedge clock);
    hold(i, 1);
    repeat (3) @(posedge clock);
    rd_chk(fault_monitor_pkg::ADDR_CONTROL, ce);
    if (ae !== 16'h0000) rd_chk(fault_monitor_pkg::ADDR_ALARM, ae);
    chk(16'(rr_cnt - r), 16'(n));
    wr_reg(fault_monitor_pkg::ADDR_ALARM, 16'hFFFF);
    wr_reg(fault_monitor_pkg::ADDR_CONTROL, 16'h0000);
  endtask : run_case

  task automatic echo_case(input logic [1:0] m, input logic [15:0] w, input int n);
    int r;
    r = rr_cnt;
    mode <= m;
    mbw <= w;
    repeat (4) @(posedge clock);
    hold(12, 1);
    repeat (12) @(posedge clock);
    chk(16'(rr_cnt - r), 16'(n));
  endtask : echo_case

  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    rd_chk(fault_monitor_pkg::ADDR_ALARM, 16'h0000);
    rd_chk(fault_monitor_pkg::ADDR_MASK, 16'h0000);
    rd_chk(fault_monitor_pkg::ADDR_CONTROL, 16'h0000);
    rd_chk(fault_monitor_pkg::ADDR_STATUS, 16'h0000);
    rd_chk(3'h7, 16'h0000);
    run_case(0, 1'b0, 16'h0007, 16'h0002, 16'h0000, 0);
    run_case(1, 1'b0, 16'h0007, 16'h0002, 16'h0200, 0);
    run_case(1, 1'b1, 16'h0007, 16'h0007, 16'h0200, 0);
    run_case(3, 1'b1, 16'h0007, 16'h0007, 16'h0400, 0);
    run_case(4, 1'b1, 16'h0007, 16'h0007, 16'h1000, 0);
    run_case(4, 1'b0, 16'h0007, 16'h0002, 16'h1000, 0);
    run_case(5, 1'b1, 16'h000B, 16'h0002, 16'h1000, 0);
    run_case(2, 1'b0, 16'h0007, 16'h0007, 16'h0040, 0);
    run_case(6, 1'b0, 16'h0000, 16'h0000, 16'h2000, 1);
    run_case(7, 1'b0, 16'h0000, 16'h0000, 16'h4000, 1);
    wr_reg(fault_monitor_pkg::ADDR_MASK, 16'h1000);
    hold(4, 1);
    repeat (3) @(posedge clock);
    chk({15'h0000, irq}, 16'h0001);
    wr_reg(fault_monitor_pkg::ADDR_ALARM, 16'hFFFF);
    repeat (2) @(posedge clock);
    chk({15'h0000, irq}, 16'h0000);
    lv[1] <= 1'b1;
    repeat (6) @(posedge clock);
    lv[1] <= 1'b0;
    repeat (6) @(posedge clock);
    rd_chk(fault_monitor_pkg::ADDR_ALARM, 16'h0010);
    wr_reg(fault_monitor_pkg::ADDR_ALARM, 16'hFFFF);
    wr_reg(fault_monitor_pkg::ADDR_CONTROL, 16'h0003);
    lv[2] <= 1'b1;
    repeat (6) @(posedge clock);
    rd_chk(fault_monitor_pkg::ADDR_CONTROL, 16'h0012);
    rd_chk(fault_monitor_pkg::ADDR_ALARM, 16'h0100);
    lv[2] <= 1'b0;
    repeat (4) @(posedge clock);
    wr_reg(fault_monitor_pkg::ADDR_ALARM, 16'hFFFF);
    hold(9, 1);
    wr_reg(fault_monitor_pkg::ADDR_CONTROL, 16'h0023);
    repeat (2) hold(8, 1);
    rd_chk(fault_monitor_pkg::ADDR_ALARM, 16'h0000);
    hold(8, 1);
    repeat (3) @(posedge clock);
    rd_chk(fault_monitor_pkg::ADDR_CONTROL, 16'h0002);
    rd_chk(fault_monitor_pkg::ADDR_ALARM, 16'h0800);
    wr_reg(fault_monitor_pkg::ADDR_ALARM, 16'hFFFF);
    for (int k = 1024; k >= 1023; k--) begin
      wr_reg(fault_monitor_pkg::ADDR_CONTROL, 16'h0000);
      wr_reg(fault_monitor_pkg::ADDR_CONTROL, 16'h0007);
      repeat (3) @(posedge clock);
      hold(10, k);
      hold(11, 1);
      repeat (3) @(posedge clock);
      rd_chk(fault_monitor_pkg::ADDR_ALARM, (k == 1024) ? 16'h0000 : 16'h0080);
    end
    chk({15'h0000, ten}, 16'h0000);
    wr_reg(fault_monitor_pkg::ADDR_ALARM, 16'hFFFF);
    wr_reg(fault_monitor_pkg::ADDR_CONTROL, 16'h0000);
    echo_case(2'h0, 16'hA5C3, 0);
    echo_case(2'h1, 16'hA5C3, 1);
    echo_case(2'h2, 16'hFFFF, 1);
    echo_case(2'h0, 16'h0000, 0);
    for (int m = 0; m < 4; m += 3) begin
      mode <= 2'(m);
      hold(13, 1);
      repeat (4) @(posedge clock);
      hold(14, 1);
      repeat (6) @(posedge clock);
      rd_chk(fault_monitor_pkg::ADDR_ALARM, (m == 3) ? 16'h8002 : 16'h0000);
    end
    chk({15'h0000, amp}, 16'h0001);
    chk(drv, 16'h0000);
    test_done();
  end
endmodule : tb
